//--- dv/spi_i2c_serial_shifter_asserts.sv
`timescale 1ns/1ps
module spi_i2c_serial_shifter_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic tie_sda,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic dev_dout_oe,
  input wire logic far_sck_o,
  input wire logic far_sck_oe,
  input wire logic sck,
  input wire logic ss_n
);
  // Cycles with select low; saturates so a long hold cannot wrap
  logic [7:0] low_len_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) low_len_q <= 8'h00;
    else if (ss_n) low_len_q <= 8'h00;
    else if (low_len_q != 8'hff) low_len_q <= low_len_q + 8'h01;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_RST_DEV_SCK: assert property ($fell(i_rst) |-> !dev_sck_oe)
    else $error("device drives clock after reset");
  AST_RST_DEV_DOUT: assert property ($fell(i_rst) |-> !dev_dout_oe)
    else $error("device drives data after reset");
  AST_RST_FAR: assert property ($fell(i_rst) |-> ss_n && !far_sck_oe)
    else $error("far end active after reset");
  AST_ONE_CLOCK_DRIVER: assert property (!tie_sda |-> !(dev_sck_oe && far_sck_oe))
    else $error("two clock drivers");
  AST_DOUT_RELEASE: assert property ($rose(ss_n) && !tie_sda && !dev_sck_oe |-> ##[1:6] !dev_dout_oe)
    else $error("slave data not released");
  AST_SS_SPAN: assert property ($rose(ss_n) && !tie_sda |-> low_len_q > 8'd120)
    else $error("select released early");
  AST_SS_LEAD: assert property ($fell(ss_n) && !tie_sda |=> $stable(far_sck_o) [*4])
    else $error("clock moved with select");
  AST_STRETCH_LOW: assert property (tie_sda && $rose(dev_sck_oe && !dev_sck_o) |-> !$past(sck))
    else $error("stretch cut a high clock");
endmodule : spi_i2c_serial_shifter_asserts

//--- dv/spi_i2c_serial_shifter_tb_top.sv
`timescale 1ns/1ps
module spi_i2c_serial_shifter_tb_top;
  import spi_i2c_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, cmd_valid = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, tx_data = 8'h00, o_rdata, rx_data, d, ctl;
  logic bit_irq, ss_irq, done, rx_ack;
  host_cmd_type cmd = CMD_SPI;
  int fail_count = 0, check_count = 0, cycles = 0;
  serial_link_if link();
  // 200 MHz system clock
  always #2.5 i_clk = ~i_clk;
  // Timer and strobe sources stay quiet: only the far master clocks the link here
  serial_shifter_dev serial_shifter_dev_i (.i_clk(i_clk), .i_rst(i_rst), .link(link.device), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_wr_pulse(1'b0), .i_timer0_ovf(1'b0),
    .i_timer1_ovf(1'b0), .o_bit_count_irq(bit_irq), .o_start_stop_irq(ss_irq));
  serial_link_far serial_link_far_i (.i_clk(i_clk), .i_rst(i_rst), .link(link.far), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_tx_data(tx_data), .i_tx_ack(1'b1), .i_cpol(cpol), .i_cpha(cpha), .i_lsb_first(lsb),
    .i_slave_mode(1'b0), .o_busy(), .o_done(done), .o_rx_data(rx_data), .o_rx_ack(rx_ack));
  spi_i2c_serial_shifter_asserts spi_i2c_serial_shifter_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
    .tie_sda(link.tie_sda), .dev_sck_o(link.dev_sck_o), .dev_sck_oe(link.dev_sck_oe), .dev_dout_oe(link.dev_dout_oe),
    .far_sck_o(link.far_sck_o), .far_sck_oe(link.far_sck_oe), .sck(link.sck), .ss_n(link.ss_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd_chk
  task automatic far_go(input host_cmd_type c, input logic [7:0] v);
    @(posedge i_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    tx_data <= v;
    @(posedge i_clk);
    cmd_valid <= 1'b0;
  endtask : far_go
  // Waits for far done (0) or the count flag (1); gives up after 4000 cycles
  task automatic wait_for(input bit flag);
    for (int n = 0; n < 4000; n++) begin
      @(posedge i_clk);
      #1;
      if (flag ? bit_irq === 1'b1 : done === 1'b1) break;
    end
  endtask : wait_for
  task automatic end_sim;
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    link.tie_sda = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(PERIPHERAL_POWER_DOWN_REG_ADDR, {7'h00, PD_RESET});
    rd_chk(8'h80, 8'h00);
    wr_reg(PERIPHERAL_POWER_DOWN_REG_ADDR, 8'h00);
    wr_reg(SERIAL_MODE_REG_ADDR, 8'h00);
    // Device as select-gated slave in all four clock modes, both bit orders
    for (int i = 0; i < 4; i++) begin
      d = 8'h35 + 8'(i * 68);
      ctl = {4'h0, 1'b1, i[0] ^ i[1], i[1], i[0]};
      wr_reg(SERIAL_CONTROL_REG_ADDR, ctl);
      cpol <= i[0];
      cpha <= i[1];
      lsb <= i[0] ^ i[1];
      wr_reg(SERIAL_SHIFT_DATA_ADDR, ~d);
      far_go(CMD_SPI, d);
      wait_for(1'b0);
      chk({7'h00, bit_irq}, 8'h01);
      chk(rx_data, ~d);
      rd_chk(SERIAL_SHIFT_DATA_ADDR, d);
      chk({7'h00, bit_irq}, 8'h00);
      rd_chk(SERIAL_CONTROL_REG_ADDR, ctl);
    end
    // Unread byte is lost to the next exchange
    far_go(CMD_SPI, 8'ha5);
    wait_for(1'b0);
    far_go(CMD_SPI, 8'h3c);
    wait_for(1'b0);
    chk({7'h00, bit_irq}, 8'h01);
    rd_chk(SERIAL_SHIFT_DATA_ADDR, 8'h3c);
    // Two-wire slave: release SDA before joining the bus
    wr_reg(TWOWIRE_SHIFT_DATA_ADDR, 8'hff);
    wr_reg(SERIAL_MODE_REG_ADDR, 8'h01);
    link.tie_sda <= 1'b1;
    far_go(CMD_START, 8'h00);
    wait_for(1'b0);
    chk({7'h00, ss_irq}, 8'h01);
    wr_reg(SERIAL_STATUS_REG_ADDR, 8'h02);
    // Enabling reception restarts the counter past the clock fall that ends START
    wr_reg(TWOWIRE_SHIFT_DATA_ADDR, 8'hff);
    far_go(CMD_BYTE, 8'hc6);
    wait_for(1'b1);
    rd_chk(TWOWIRE_SHIFT_DATA_ADDR, 8'hc6);
    wr_reg(TWOWIRE_SHIFT_DATA_ADDR, 8'h7f);
    wait_for(1'b0);
    chk({7'h00, rx_ack}, 8'h00);
    wait_for(1'b1);
    chk({7'h00, bit_irq}, 8'h01);
    far_go(CMD_STOP, 8'h00);
    wait_for(1'b0);
    // STOP lands with done; the flag follows through the device's synchroniser
    repeat (5) @(posedge i_clk);
    chk({7'h00, ss_irq}, 8'h01);
    wr_reg(SERIAL_MODE_REG_ADDR, 8'h05);
    far_go(CMD_START, 8'h00);
    wait_for(1'b0);
    rd_chk(SERIAL_MODE_REG_ADDR, 8'h01);
    far_go(CMD_STOP, 8'h00);
    wait_for(1'b0);
    end_sim();
  end
endmodule : spi_i2c_serial_shifter_tb_top

//--- hw/serial_link_far.sv
`timescale 1ns/1ps
module serial_link_far
  import spi_i2c_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  serial_link_if.far link,
  input wire logic i_cmd_valid,
  input wire host_cmd_type i_cmd,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_ack,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_lsb_first,
  input wire logic i_slave_mode,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rx_data,
  output logic o_rx_ack
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_SPI = 7'h02, ST_ILOW = 7'h04, ST_IHIGH = 7'h08,
    ST_START = 7'h10, ST_STOP = 7'h20, ST_STOPB = 7'h40
  } host_state_type;

  host_state_type state_q;
  logic [1:0] meta_q, sync_q;
  logic sck_prev_q;
  logic [3:0] div_q;
  logic sck_q, sck_oe_q, data_q, data_oe_q, ss_n_q, ph_q, busy_q, done_q, ack_q;
  logic [8:0] tx_q;
  logic [7:0] rx_q;
  logic [4:0] edge_q;
  logic tick, sck_s, din_s, s_rise, s_fall, s_sample, s_shift;

  // Two flip-flops on the line inputs; only the second stage is looked at
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      sck_prev_q <= 1'b1;
    end else begin
      meta_q <= {link.sck, link.dout_line};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
    end
  end

  assign sck_s = sync_q[1];
  assign din_s = sync_q[0];
  assign s_rise = sck_s && !sck_prev_q;
  assign s_fall = !sck_s && sck_prev_q;
  assign s_sample = (i_cpol == i_cpha) ? s_rise : s_fall;
  assign s_shift = (i_cpol == i_cpha) ? s_fall : s_rise;
  assign tick = (div_q == HOST_HALF_CYCLES - 4'h1);

  // Half-period divider; runs only while a command is in progress
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 4'h0;
    end else if (state_q == ST_IDLE || tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Command sequencer and bit engine
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      sck_q <= 1'b1;
      sck_oe_q <= 1'b0;
      data_q <= 1'b1;
      data_oe_q <= 1'b0;
      ss_n_q <= 1'b1;
      ph_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b1;
      tx_q <= 9'h1ff;
      rx_q <= 8'h00;
      edge_q <= 5'h00;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_cmd_valid) begin
            ph_q <= 1'b0;
            edge_q <= 5'h00;
            case (i_cmd)
              CMD_SPI: begin
                tx_q <= {1'b0, i_tx_data};
                data_q <= i_lsb_first ? i_tx_data[0] : i_tx_data[7];
                data_oe_q <= 1'b1;
                if (!i_slave_mode) begin
                  sck_q <= i_cpol;
                  sck_oe_q <= 1'b1;
                  busy_q <= 1'b1;
                  state_q <= ST_SPI;
                end
              end
              CMD_START: begin
                sck_q <= 1'b0;
                data_q <= 1'b0;
                busy_q <= 1'b1;
                state_q <= ST_START;
              end
              CMD_BYTE: begin
                tx_q <= {i_tx_data, i_tx_ack};
                sck_q <= 1'b0;
                data_q <= 1'b0;
                busy_q <= 1'b1;
                state_q <= ST_ILOW;
              end
              default: begin
                sck_q <= 1'b0;
                data_q <= 1'b0;
                busy_q <= 1'b1;
                state_q <= ST_STOP;
              end
            endcase
          end else if (i_slave_mode && s_sample) begin
            // Slave exchange on the device's clock
            rx_q <= shift_in(rx_q, din_s, i_lsb_first);
            edge_q <= (edge_q == 5'h07) ? 5'h00 : edge_q + 5'h01;
            done_q <= (edge_q == 5'h07);
          end else if (i_slave_mode && s_shift && edge_q != 5'h00) begin
            tx_q <= i_lsb_first ? {1'b0, 1'b0, tx_q[7:1]} : {1'b0, tx_q[6:0], 1'b0};
            data_q <= i_lsb_first ? tx_q[1] : tx_q[6];
          end
        end
        ST_SPI: begin
          // Select falls a cycle after the clock takes its idle level, so that step is never a first edge
          if (!tick) begin
            ss_n_q <= 1'b0;
          end else begin
            if (edge_q == 5'h10) begin
              ss_n_q <= 1'b1;
              // Both lines are let go so a two-wire phase can follow on the same pins
              sck_oe_q <= 1'b0;
              data_oe_q <= 1'b0;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              sck_q <= !sck_q;
              edge_q <= edge_q + 5'h01;
              if (edge_q[0] == i_cpha) begin
                rx_q <= shift_in(rx_q, din_s, i_lsb_first);
              end else if (edge_q != 5'h00) begin
                tx_q <= i_lsb_first ? {1'b0, 1'b0, tx_q[7:1]} : {1'b0, tx_q[6:0], 1'b0};
                data_q <= i_lsb_first ? tx_q[1] : tx_q[6];
              end
            end
          end
        end
        ST_ILOW: begin
          // Data moves only with the clock held low, then the clock is released
          if (tick && !ph_q) begin
            data_oe_q <= !tx_q[8];
            ph_q <= 1'b1;
          end else if (tick) begin
            sck_oe_q <= 1'b0;
            ph_q <= 1'b0;
            state_q <= ST_IHIGH;
          end
        end
        ST_IHIGH: begin
          // A slave holding the clock low delays this step
          if (tick && sck_s) begin
            sck_oe_q <= 1'b1;
            if (edge_q == 5'h08) begin
              ack_q <= din_s;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              rx_q <= shift_in(rx_q, din_s, 1'b0);
              tx_q <= {tx_q[7:0], 1'b1};
              edge_q <= edge_q + 5'h01;
              state_q <= ST_ILOW;
            end
          end
        end
        ST_START: begin
          if (tick && !ph_q) begin
            data_oe_q <= 1'b1;
            ph_q <= 1'b1;
          end else if (tick) begin
            sck_oe_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_STOP: begin
          if (tick && !ph_q) begin
            data_oe_q <= 1'b1;
            ph_q <= 1'b1;
          end else if (tick) begin
            sck_oe_q <= 1'b0;
            state_q <= ST_STOPB;
          end
        end
        ST_STOPB: begin
          if (tick && sck_s) begin
            data_oe_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.far_sck_o = sck_q;
  assign link.far_sck_oe = sck_oe_q;
  assign link.far_data_o = data_q;
  assign link.far_data_oe = data_oe_q;
  assign link.far_ss_n = ss_n_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_rx_data = rx_q;
  assign o_rx_ack = ack_q;
endmodule : serial_link_far

//--- hw/serial_link_if.sv
`timescale 1ns/1ps
interface serial_link_if;
  // Bench sets this when data in and data out are tied as one two-wire data line
  logic tie_sda;
  logic dev_sck_o, dev_sck_oe, dev_dout_o, dev_dout_oe;
  logic far_sck_o, far_sck_oe, far_data_o, far_data_oe, far_ss_n;
  logic sck, din_line, dout_line, ss_n;
  // Pulled-up lines: a driven low wins, so open drain and push-pull both resolve
  assign sck = !((dev_sck_oe && !dev_sck_o) || (far_sck_oe && !far_sck_o));
  assign dout_line = !((dev_dout_oe && !dev_dout_o) || (tie_sda && far_data_oe && !far_data_o));
  assign din_line = !((far_data_oe && !far_data_o) || (tie_sda && dev_dout_oe && !dev_dout_o));
  assign ss_n = far_ss_n;
  modport device(input sck, din_line, ss_n, output dev_sck_o, dev_sck_oe, dev_dout_o, dev_dout_oe);
  modport far(input sck, dout_line, output far_sck_o, far_sck_oe, far_data_o, far_data_oe, far_ss_n);
endinterface : serial_link_if

//--- hw/serial_shifter_dev.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module serial_shifter_dev
  import spi_i2c_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  serial_link_if.device link,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_wr_pulse,
  input wire logic i_timer0_ovf,
  input wire logic i_timer1_ovf,
  output logic o_bit_count_irq,
  output logic o_start_stop_irq
);
  // Both data register addresses reach the same shifter
  function automatic logic is_data_addr(input logic [7:0] a);
    return (a == SERIAL_SHIFT_DATA_ADDR) || (a == TWOWIRE_SHIFT_DATA_ADDR);
  endfunction : is_data_addr

  logic [2:0] meta_q, sync_q, prev_q;
  logic [3:0] ctl_q, pin_q, cnt_q;
  logic [1:0] mode_q;
  logic dcs_q, pd_q, tog_q, pend_q, in_bit_q, ack_phase_q;
  logic cnt_flag_q, ss_flag_q, stretch_q;
  logic sck_o_q, sck_oe_q, dout_o_q, dout_oe_q;
  logic [2:0] src_q, pulse_q;
  logic [7:0] shift_q, rdata_q;
  logic sck_now, din_now, ss_high, active, is_i2c, is_master, lsb, out_bit;
  logic data_wr, data_acc, rise, fall, start_det, stop_det, sample_edge, shift_edge;
  logic ss_block, cnt_event, cnt_set, withdraw, src_ev, pulse_src, pulse_ok, gen;
  logic [3:0] cnt_nx;

  // Line inputs pass two flip-flops; edges come from the second stage only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      prev_q <= 3'h7;
    end else begin
      meta_q <= {link.sck, link.din_line, link.ss_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sck_now = sync_q[2];
  assign din_now = sync_q[1];
  assign ss_high = sync_q[0];
  assign active = !pd_q;
  assign is_i2c = mode_q[MODE_I2C];
  assign is_master = mode_q[MODE_MASTER];
  assign lsb = !is_i2c && ctl_q[CTL_LSB];
  assign out_bit = lsb ? shift_q[0] : shift_q[7];
  assign data_wr = i_wr && is_data_addr(i_addr);
  assign data_acc = data_wr || (i_rd && is_data_addr(i_addr));
  assign rise = sck_now && !prev_q[2];
  assign fall = !sck_now && prev_q[2];
  // Data moving while the clock stays high marks START (falling) or STOP (rising)
  assign start_det = active && is_i2c && sck_now && prev_q[2] && prev_q[1] && !din_now;
  assign stop_det = active && is_i2c && sck_now && prev_q[2] && !prev_q[1] && din_now;
  assign sample_edge = (is_i2c || ctl_q[CTL_CPOL] == ctl_q[CTL_CPHA]) ? rise : fall;
  assign shift_edge = (is_i2c || ctl_q[CTL_CPOL] == ctl_q[CTL_CPHA]) ? fall : rise;
  assign ss_block = !is_i2c && !is_master && ctl_q[CTL_SSE] && ss_high;
  assign cnt_event = active && !ss_block && !data_acc && !start_det && !stop_det
                     && (is_i2c ? fall : sample_edge);
  assign cnt_nx = (cnt_q == BYTE_BITS) ? 4'h1 : cnt_q + 4'h1;
  // A byte, or in two-wire mode the acknowledge after it, raises the count flag
  assign cnt_set = cnt_event && !(is_i2c && dcs_q)
                   && ((cnt_nx == BYTE_BITS) || (is_i2c && ack_phase_q && cnt_nx == 4'h1));
  assign withdraw = !is_i2c && cnt_event && cnt_q == BYTE_BITS;

  // Shifter and bit counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= SHIFT_RESET;
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
      in_bit_q <= 1'b0;
    end else if (!active) begin
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
    end else if (data_acc) begin
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
      if (data_wr) begin
        shift_q <= i_wdata;
      end
    end else if (start_det || stop_det) begin
      cnt_q <= 4'h0;
      pend_q <= 1'b0;
    end else if (!ss_block) begin
      if (sample_edge) begin
        in_bit_q <= din_now;
        // Outside two-wire mode the last bit of a byte goes in at once so the byte is whole with the flag
        if (!is_i2c && cnt_nx == BYTE_BITS) begin
          shift_q <= shift_in(shift_q, din_now, lsb);
          pend_q <= 1'b0;
        end else begin
          pend_q <= 1'b1;
        end
      end else if (shift_edge && pend_q) begin
        shift_q <= shift_in(shift_q, in_bit_q, lsb);
        pend_q <= 1'b0;
      end
      if (cnt_event) begin
        cnt_q <= cnt_nx;
      end
    end
  end

  // Event flags; a set in the same cycle as a clear wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_flag_q <= 1'b0;
      ss_flag_q <= 1'b0;
      stretch_q <= 1'b0;
      ack_phase_q <= 1'b0;
    end else begin
      if (cnt_set) begin
        cnt_flag_q <= 1'b1;
      end else if (data_acc || withdraw || !active) begin
        cnt_flag_q <= 1'b0;
      end
      if (start_det || stop_det) begin
        ss_flag_q <= 1'b1;
      end else if (i_wr && i_addr == SERIAL_STATUS_REG_ADDR && i_wdata[STAT_SS]) begin
        ss_flag_q <= 1'b0;
      end
      if (is_i2c && !is_master && cnt_set && cnt_nx == BYTE_BITS) begin
        stretch_q <= 1'b1;
      end else if (data_wr || !active || !is_i2c) begin
        stretch_q <= 1'b0;
      end
      // A whole byte opens the acknowledge slot, unless a data register access falls in the same cycle
      if (is_i2c && cnt_event && cnt_nx == BYTE_BITS) begin
        ack_phase_q <= 1'b1;
      end else if (cnt_event || start_det || stop_det) begin
        ack_phase_q <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_q <= 4'h0;
      mode_q <= 2'h0;
      dcs_q <= 1'b0;
      pd_q <= PD_RESET;
      src_q <= SRC_SOFT;
      pin_q <= 4'h0;
    end else if (i_wr) begin
      case (i_addr)
        SERIAL_CONTROL_REG_ADDR: ctl_q <= i_wdata[3:0];
        SERIAL_MODE_REG_ADDR: begin
          mode_q <= i_wdata[1:0];
          dcs_q <= i_wdata[MODE_DCS];
        end
        PERIPHERAL_POWER_DOWN_REG_ADDR: pd_q <= i_wdata[PD_SERIAL];
        PORT_CLOCK_SOURCE_SELECT_ADDR: src_q <= i_wdata[2:0];
        SERIAL_PIN_REG_ADDR: pin_q <= i_wdata[3:0];
        default: ;
      endcase
    end else if (start_det) begin
      dcs_q <= 1'b0;
    end
  end

  // Master clock source; the strobe and timer events come from this clock domain
  always_comb begin
    case (src_q)
      SRC_WR_PULSE, SRC_WR_TOGGLE: src_ev = i_ext_wr_pulse;
      SRC_T0_PULSE, SRC_T0_TOGGLE: src_ev = i_timer0_ovf;
      SRC_T1_PULSE, SRC_T1_TOGGLE: src_ev = i_timer1_ovf;
      default: src_ev = 1'b0;
    endcase
  end

  assign pulse_src = (src_q == SRC_WR_PULSE) || (src_q == SRC_T0_PULSE) || (src_q == SRC_T1_PULSE);
  // A pulse whose idle level disagrees with the polarity would add a false edge
  assign pulse_ok = (src_q == SRC_WR_PULSE) ? ctl_q[CTL_CPOL] : !ctl_q[CTL_CPOL];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tog_q <= 1'b0;
      pulse_q <= 3'h0;
    end else begin
      if (src_ev && !pulse_src) begin
        tog_q <= !tog_q;
      end
      if (src_ev && pulse_src && pulse_ok) begin
        pulse_q <= PULSE_CYCLES;
      end else if (pulse_q != 3'h0) begin
        pulse_q <= pulse_q - 3'h1;
      end
    end
  end

  always_comb begin
    case (src_q)
      SRC_SOFT: gen = pin_q[PIN_SCK];
      SRC_WR_PULSE: gen = (pulse_q == 3'h0);
      SRC_T0_PULSE, SRC_T1_PULSE: gen = (pulse_q != 3'h0);
      default: gen = tog_q;
    endcase
  end

  // Pin drivers, registered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_o_q <= 1'b0;
      sck_oe_q <= 1'b0;
      dout_o_q <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (!active) begin
      sck_o_q <= pin_q[PIN_SCK];
      sck_oe_q <= pin_q[PIN_SCK_OE];
      dout_o_q <= pin_q[PIN_DOUT];
      dout_oe_q <= pin_q[PIN_DOUT_OE];
    end else if (is_i2c) begin
      sck_o_q <= 1'b0;
      sck_oe_q <= stretch_q || (is_master && !gen);
      dout_o_q <= 1'b0;
      dout_oe_q <= !out_bit;
    end else begin
      sck_o_q <= gen;
      sck_oe_q <= is_master;
      dout_o_q <= out_bit;
      dout_oe_q <= is_master || !ss_high;
    end
  end

  // Register reads; data is valid the cycle after the strobe only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        SERIAL_SHIFT_DATA_ADDR, TWOWIRE_SHIFT_DATA_ADDR: rdata_q <= shift_q;
        SERIAL_CONTROL_REG_ADDR: rdata_q <= {cnt_q, ctl_q};
        SERIAL_MODE_REG_ADDR: rdata_q <= {5'h00, dcs_q, mode_q};
        SERIAL_STATUS_REG_ADDR: rdata_q <= {6'h00, ss_flag_q, cnt_flag_q};
        PERIPHERAL_POWER_DOWN_REG_ADDR: rdata_q <= {7'h00, pd_q};
        PORT_CLOCK_SOURCE_SELECT_ADDR: rdata_q <= {5'h00, src_q};
        SERIAL_PIN_REG_ADDR: rdata_q <= {1'b0, sync_q, pin_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign link.dev_sck_o = sck_o_q;
  assign link.dev_sck_oe = sck_oe_q;
  assign link.dev_dout_o = dout_o_q;
  assign link.dev_dout_oe = dout_oe_q;
  assign o_rdata = rdata_q;
  assign o_bit_count_irq = cnt_flag_q;
  assign o_start_stop_irq = ss_flag_q;
endmodule : serial_shifter_dev

//--- hw/spi_i2c_pkg.sv
package spi_i2c_pkg;
  // Register offsets
  localparam logic [7:0] TWOWIRE_SHIFT_DATA_ADDR = 8'h9b;
  localparam logic [7:0] PORT_CLOCK_SOURCE_SELECT_ADDR = 8'hf2;
  localparam logic [7:0] PERIPHERAL_POWER_DOWN_REG_ADDR = 8'hf1;
  localparam logic [7:0] SERIAL_SHIFT_DATA_ADDR = 8'h9a;
  localparam logic [7:0] SERIAL_CONTROL_REG_ADDR = 8'h9c;
  localparam logic [7:0] SERIAL_MODE_REG_ADDR = 8'h9d;
  localparam logic [7:0] SERIAL_STATUS_REG_ADDR = 8'h9e;
  localparam logic [7:0] SERIAL_PIN_REG_ADDR = 8'h9f;
  // Field positions
  localparam int CTL_CPOL = 0;
  localparam int CTL_CPHA = 1;
  localparam int CTL_LSB = 2;
  localparam int CTL_SSE = 3;
  localparam int MODE_I2C = 0;
  localparam int MODE_MASTER = 1;
  localparam int MODE_DCS = 2;
  localparam int STAT_CNT = 0;
  localparam int STAT_SS = 1;
  localparam int PD_SERIAL = 0;
  localparam int PIN_SCK = 0;
  localparam int PIN_DOUT = 1;
  localparam int PIN_SCK_OE = 2;
  localparam int PIN_DOUT_OE = 3;
  // Values after reset, and the byte length
  localparam logic [7:0] SHIFT_RESET = 8'hff;
  localparam logic PD_RESET = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Clock sources of the serial clock in master mode
  typedef enum logic [2:0] {
    SRC_SOFT = 3'h0, SRC_WR_PULSE = 3'h1, SRC_WR_TOGGLE = 3'h2, SRC_T0_PULSE = 3'h3,
    SRC_T0_TOGGLE = 3'h4, SRC_T1_PULSE = 3'h5, SRC_T1_TOGGLE = 3'h6
  } clk_src_type;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PULSE_NS = 20;
  localparam logic [2:0] PULSE_CYCLES = 3'((PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int HOST_HALF_NS = 40;
  localparam logic [3:0] HOST_HALF_CYCLES = 4'((HOST_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Far-end commands
  typedef enum logic [1:0] {CMD_SPI = 2'h0, CMD_START = 2'h1, CMD_BYTE = 2'h2, CMD_STOP = 2'h3} host_cmd_type;

  // Shift one bit into a byte in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
    return lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in
endpackage : spi_i2c_pkg
